// File: rtl/lsp_io_ports.sv
// two 8-bit i/o ports: lcd-shared first port, analog-shared second port
//
// Notes on behaviour
// - first port: dir 1, seg 0 drives latch
// - seg bit 1 hands pin to lcd
// - reset clears first latch, dir, seg
// - first read: dir0 seg0 gives pin level
// - first read: dir0 seg1 gives zero
// - first read: dir1 gives latch bit
// - second port: dir 1 drives latch
// - dir0 ie1 passes pin to reads, timers
// - dir0 ie0 blocks digital input, reads zero
// - second read: dir1 gives latch bit
// - reset clears second latch, dir; ie ones
// - port never picks the conversion channel
// - written value lands in every latch bit
`timescale 1ns/1ns
`default_nettype none
module lsp_io_ports (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lsp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // first port pins and lcd segment source
  input wire logic [7:0] first_pin_in,
  input wire logic [7:0] lcd_seg_in,
  output lsp_pkg::lsp_pad_drv_t first_pad,
  // second port pins and digital input fan-out
  input wire logic [7:0] second_pin_in,
  output lsp_pkg::lsp_pad_drv_t second_pad,
  output logic [7:0] second_dig_in
);

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // true when the byte address selects the register index
  function automatic logic addr_hit(input logic [15:0] a, input logic [11:0] idx);
    addr_hit = (a == {2'h0, idx, 2'h0});
  endfunction : addr_hit

  logic hit_fl, hit_sl, hit_fd, hit_sd, hit_ie, hit_fs; // per-register selects
  logic mapped; // any register selected
  logic wr_en; // write takes effect at this edge
  logic rd_setup; // setup cycle of a read

  assign hit_fl = addr_hit(paddr, lsp_pkg::IDX_FIRST_LATCH);
  assign hit_sl = addr_hit(paddr, lsp_pkg::IDX_SECOND_LATCH);
  assign hit_fd = addr_hit(paddr, lsp_pkg::IDX_FIRST_DIR);
  assign hit_sd = addr_hit(paddr, lsp_pkg::IDX_SECOND_DIR);
  assign hit_ie = addr_hit(paddr, lsp_pkg::IDX_SECOND_IE);
  assign hit_fs = addr_hit(paddr, lsp_pkg::IDX_FIRST_SEG);
  assign mapped = hit_fl | hit_sl | hit_fd | hit_sd | hit_ie | hit_fs;
  // zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  // unmapped address answers with an error, writes ignored
  // a read of an unmapped address also returns zero data
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] first_latch_reg_q; // first port output latch
  logic [7:0] first_dir_q; // first port direction, 1 = output
  logic [7:0] first_seg_q; // first port segment select, 1 = lcd
  logic [7:0] second_latch_q; // second port output latch
  logic [7:0] second_dir_q; // second port direction, 1 = output
  logic [7:0] second_ie_q; // second port digital input enable

  // first port registers; the whole written byte lands in the latch
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      first_latch_reg_q <= lsp_pkg::RST_FIRST_LATCH;
      first_dir_q <= lsp_pkg::RST_FIRST_DIR;
      first_seg_q <= lsp_pkg::RST_FIRST_SEG;
    end else if (wr_en) begin
      // input-mode bits take whatever a bit instruction wrote back
      if (hit_fl) first_latch_reg_q <= pwdata[7:0];
      if (hit_fd) first_dir_q <= pwdata[7:0];
      if (hit_fs) first_seg_q <= pwdata[7:0];
    end
  end

  // writes to unmapped addresses fall through every hit and are lost
  // second port registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      second_latch_q <= lsp_pkg::RST_SECOND_LATCH;
      second_dir_q <= lsp_pkg::RST_SECOND_DIR;
      second_ie_q <= lsp_pkg::RST_SECOND_IE;
    end else if (wr_en) begin
      if (hit_sl) second_latch_q <= pwdata[7:0];
      if (hit_sd) second_dir_q <= pwdata[7:0];
      if (hit_ie) second_ie_q <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read composition

  logic [7:0] first_rd; // value a read of the first latch returns
  logic [7:0] second_rd; // value a read of the second latch returns
  logic [31:0] prdata_d; // next read data

  // per-bit read view: output bits show the latch, gated input bits the pin
  function automatic logic [7:0] compose_rd(input logic [7:0] dir, input logic [7:0] latch,
    input logic [7:0] gate, input logic [7:0] pin);
    compose_rd = (dir & latch) | (~dir & gate & pin);
  endfunction : compose_rd

  // first port: lcd-owned input bits are gated off and read zero
  assign first_rd = compose_rd(first_dir_q, first_latch_reg_q,
    ~first_seg_q, first_pin_in);
  // second port: input bits with the input path off read zero
  assign second_rd = compose_rd(second_dir_q, second_latch_q,
    second_ie_q, second_pin_in);

  // read mux, upper bits zero, unmapped reads zero
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_fl) prdata_d[7:0] = first_rd;
    else if (hit_sl) prdata_d[7:0] = second_rd;
    else if (hit_fd) prdata_d[7:0] = first_dir_q;
    else if (hit_sd) prdata_d[7:0] = second_dir_q;
    else if (hit_ie) prdata_d[7:0] = second_ie_q;
    else if (hit_fs) prdata_d[7:0] = first_seg_q;
    else prdata_d = 32'h0000_0000;
  end

  // capturing at setup keeps the pin sample a cycle ahead of the take,
  // so a pin that moves during the access cycle cannot tear the read
  // read data captured at setup, stands through the access cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prdata <= lsp_pkg::RST_PRDATA;
    end else if (rd_setup) begin
      prdata <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad drive

  wire [7:0] first_oe_w; // per-bit first port drive enable
  wire [7:0] first_dout_w; // per-bit first port drive level
  wire [7:0] second_oe_w; // per-bit second port drive enable
  wire [7:0] second_dout_w; // per-bit second port drive level

  // one pad slice per bit, identical for all eight
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pad
      // lcd segment owns the pin whatever latch and direction hold
      assign first_oe_w[gi] = first_seg_q[gi] | first_dir_q[gi];
      assign first_dout_w[gi] = first_seg_q[gi] ? lcd_seg_in[gi]
        : first_latch_reg_q[gi];
      // second port drives whenever direction is out, ie ignored
      assign second_oe_w[gi] = second_dir_q[gi];
      assign second_dout_w[gi] = second_latch_q[gi];
    end
  endgenerate

  // pack the slices into the pad carriers, one driver per carrier
  always_comb begin
    first_pad.dout = first_dout_w;
    first_pad.oe = first_oe_w;
    second_pad.dout = second_dout_w;
    second_pad.oe = second_oe_w;
  end
  // digital path to timers and interrupts; no channel choice here
  assign second_dig_in = ~second_dir_q & second_ie_q & second_pin_in;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // the checks below watch only what this block drives; bus and pin
  // inputs are whatever the surrounding system presents

  AST_FIRST_DRIVE: assert property (
    ((first_pad.oe & ~first_seg_q) == (first_dir_q & ~first_seg_q)) &&
    (((first_pad.dout ^ first_latch_reg_q) & first_dir_q & ~first_seg_q) == 8'h00))
    else $error("first port output bit not driven from latch");

  AST_FIRST_LCD: assert property (
    ((first_pad.oe & first_seg_q) == first_seg_q) &&
    (((first_pad.dout ^ lcd_seg_in) & first_seg_q) == 8'h00))
    else $error("segment bit not handed to lcd");

  AST_RESET_VALUES: assert property (@(posedge mclk) disable iff (1'b0)
    !rstn |=> (first_latch_reg_q == 8'h00 && first_dir_q == 8'h00 &&
    first_seg_q == 8'h00 && second_latch_q == 8'h00 &&
    second_dir_q == 8'h00 && second_ie_q == 8'hFF))
    else $error("register value after reset wrong");

  AST_FIRST_READ: assert property (
    (psel && !penable && !pwrite && hit_fl) ##1 (psel && penable) |->
    prdata == {24'h000000, $past(first_dir_q & first_latch_reg_q) |
    $past(~first_dir_q & ~first_seg_q & first_pin_in)})
    else $error("first port read value wrong");

  AST_SECOND_DRIVE: assert property (
    second_pad.oe == second_dir_q && second_pad.dout == second_latch_q)
    else $error("second port drive wrong");

  AST_SECOND_DIG: assert property (
    ((second_dig_in & ~(~second_dir_q & second_ie_q)) == 8'h00) &&
    ((second_dig_in ^ second_pin_in) & ~second_dir_q & second_ie_q) == 8'h00)
    else $error("second port digital path wrong");

  AST_SECOND_READ: assert property (
    (psel && !penable && !pwrite && hit_sl) ##1 (psel && penable) |->
    prdata == {24'h000000, $past(second_dir_q & second_latch_q) |
    $past(~second_dir_q & second_ie_q & second_pin_in)})
    else $error("second port read value wrong");

  AST_WRITE_LANDS: assert property (
    (wr_en && hit_fl) |=> first_latch_reg_q == $past(pwdata[7:0]))
    else $error("first latch write lost");

  AST_IE_WRITE: assert property (
    (wr_en && hit_ie) |=> second_ie_q == $past(pwdata[7:0]))
    else $error("input enable write lost");

  AST_UNMAPPED: assert property (
    (psel && penable && !mapped) |-> (pslverr && pready) ##1 $stable(first_dir_q))
    else $error("unmapped access not refused");

  // register write landing
  AST_WRITE_FIRST_DIR: assert property (
    (wr_en && hit_fd) |=> first_dir_q == $past(pwdata[7:0]))
    else $error("first direction write lost");

  AST_WRITE_FIRST_SEG: assert property (
    (wr_en && hit_fs) |=> first_seg_q == $past(pwdata[7:0]))
    else $error("segment select write lost");

  AST_WRITE_SECOND_LATCH: assert property (
    (wr_en && hit_sl) |=> second_latch_q == $past(pwdata[7:0]))
    else $error("second latch write lost");

  AST_WRITE_SECOND_DIR: assert property (
    (wr_en && hit_sd) |=> second_dir_q == $past(pwdata[7:0]))
    else $error("second direction write lost");

  AST_FIRST_LATCH_FREEZE: assert property (
    !(wr_en && hit_fl) |=> $stable(first_latch_reg_q))
    else $error("first latch changed without a write");

  // bus answer
  AST_ZERO_WAIT: assert property (
    (psel && penable) |-> pready)
    else $error("access cycle not answered at once");

  AST_PRDATA_HOLDS: assert property (
    !rd_setup |=> $stable(prdata))
    else $error("read data changed outside a read setup");

  AST_UNMAPPED_READ: assert property (
    (psel && !penable && !pwrite && !mapped) ##1 (psel && penable) |->
    prdata == 32'h0000_0000)
    else $error("unmapped read data not zero");

  AST_SLVERR_ACCESS: assert property (
    pslverr |-> (psel && penable && !mapped))
    else $error("error response outside an unmapped access");

  AST_NO_WRITE_UNMAPPED: assert property (
    (psel && penable && pwrite && !mapped) |=>
    ($stable(first_latch_reg_q) && $stable(second_latch_q) &&
    $stable(second_ie_q) && $stable(first_seg_q)))
    else $error("unmapped write changed a register");

  // pin views
  AST_OUT_BITS_NO_DIG: assert property (
    (second_dig_in & second_dir_q) == 8'h00)
    else $error("output bit leaks into the digital path");

  AST_PADS_AFTER_RESET: assert property (@(posedge mclk) disable iff (1'b0)
    !rstn |=> (first_pad.oe == 8'h00 && second_pad.oe == 8'h00))
    else $error("pad driven after reset");

  COV_FIRST_READ_PIN: cover property (
    (psel && !penable && !pwrite && hit_fl && first_dir_q == 8'h00) ##1 penable);
  COV_LCD_MODE: cover property (first_seg_q == 8'hFF ##1 first_seg_q == 8'hFF);
  COV_ANALOG_MODE: cover property (second_ie_q == 8'h00 && second_dir_q == 8'h00);
  COV_SECOND_WRITE: cover property (wr_en && hit_sl);
  COV_UNMAPPED_ACCESS: cover property (psel && penable && pslverr);

endmodule : lsp_io_ports
`default_nettype wire

// File: rtl/lsp_pkg.sv
// shared constants and carrier types of the two shared-function i/o ports
package lsp_pkg;
  // port width
  localparam int unsigned PORT_W = 8;
  // apb address width, wide enough for the highest register
  localparam int unsigned ADDR_W = 16;
  // register indexes; byte address is four times the index
  localparam logic [11:0] IDX_FIRST_LATCH = 12'h005;
  localparam logic [11:0] IDX_SECOND_LATCH = 12'h006;
  localparam logic [11:0] IDX_FIRST_DIR = 12'h00A;
  localparam logic [11:0] IDX_SECOND_DIR = 12'h00B;
  localparam logic [11:0] IDX_SECOND_IE = 12'h00C;
  localparam logic [11:0] IDX_FIRST_SEG = 12'hF9F;
  // values after reset
  localparam logic [7:0] RST_FIRST_LATCH = 8'h00;
  localparam logic [7:0] RST_FIRST_DIR = 8'h00;
  localparam logic [7:0] RST_FIRST_SEG = 8'h00;
  localparam logic [7:0] RST_SECOND_LATCH = 8'h00;
  localparam logic [7:0] RST_SECOND_DIR = 8'h00;
  localparam logic [7:0] RST_SECOND_IE = 8'hFF;
  // read data after reset
  localparam logic [31:0] RST_PRDATA = 32'h0000_0000;
  // drive of one 8-bit pad group
  typedef struct packed {
    logic [7:0] dout; // level driven onto the pin
    logic [7:0] oe;   // high while the pin is driven
  } lsp_pad_drv_t;
endpackage : lsp_pkg

// File: sim/lsp_pins.sv
// pin and lcd driver model at the far side of the two ports
`timescale 1ns/1ns
`default_nettype none
module lsp_pins (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // pad drive from the ports
  input wire lsp_pkg::lsp_pad_drv_t first_pad,
  input wire lsp_pkg::lsp_pad_drv_t second_pad,
  // levels from the board when nobody drives
  input wire logic [7:0] first_ext,
  input wire logic [7:0] second_ext,
  // pin levels and segment source
  output logic [7:0] first_pin_in,
  output logic [7:0] second_pin_in,
  output logic [7:0] lcd_seg_in
);
  // driven bits show the pad, the rest the board level
  assign first_pin_in = (first_pad.oe & first_pad.dout) | (~first_pad.oe & first_ext);
  assign second_pin_in = (second_pad.oe & second_pad.dout) | (~second_pad.oe & second_ext);
  //////////////////////////////////////////////////////////////////////////
  // segment pattern changes every cycle so a stale copy shows up
  always_ff @(posedge mclk) begin
    if (!rstn) lcd_seg_in <= 8'h00;
    else lcd_seg_in <= lcd_seg_in + 8'h35;
  end
endmodule : lsp_pins
`default_nettype wire

// File: sim/tb.sv
// self-checking bench of the two shared-function ports
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, pslverr, e;
  logic [7:0] f_in, s_in, lcd, s_dig, fx = 8'h96, sx = 8'h5A;
  lsp_pkg::lsp_pad_drv_t f_pad, s_pad;
  int failures = 0, tests_run = 0, cyc = 0;
  lsp_io_ports lsp_io_ports_i (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_pin_in(f_in), .lcd_seg_in(lcd), .first_pad(f_pad),
    .second_pin_in(s_in), .second_pad(s_pad), .second_dig_in(s_dig));
  lsp_pins lsp_pins_i (.mclk(mclk), .rstn(rstn), .first_pad(f_pad), .second_pad(s_pad),
    .first_ext(fx), .second_ext(sx), .first_pin_in(f_in), .second_pin_in(s_in),
    .lcd_seg_in(lcd));
  always #2 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %0t seen %h want %h", $time, s, x);
    end
  endtask : chk
  // one apb transfer, request held until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : apb
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(0, lsp_pkg::IDX_FIRST_DIR, 0); chk(r, 0);
    apb(0, lsp_pkg::IDX_FIRST_SEG, 0); chk(r, 0);
    apb(0, lsp_pkg::IDX_SECOND_DIR, 0); chk(r, 0);
    apb(0, lsp_pkg::IDX_SECOND_IE, 0); chk(r, 32'h0000_00FF);
    chk({f_pad.oe, s_pad.oe, s_dig}, {16'h0, sx});
    $display("done reset");
  endtask : t_reset
  task automatic t_first();
    apb(1, lsp_pkg::IDX_FIRST_LATCH, 8'hA5);
    apb(1, lsp_pkg::IDX_FIRST_DIR, 8'h0F);
    apb(1, lsp_pkg::IDX_FIRST_SEG, 8'h3C);
    chk(f_pad.oe, 8'h3F);
    chk(f_pad.dout & 8'h3C, lcd & 8'h3C);
    chk(f_pad.dout & 8'h03, 8'h01);
    apb(0, lsp_pkg::IDX_FIRST_LATCH, 0); chk(r, 32'h0000_0085);
    $display("done first port");
  endtask : t_first
  task automatic t_rmw();
    apb(1, lsp_pkg::IDX_FIRST_LATCH, r[7:0] | 8'h40);
    apb(1, lsp_pkg::IDX_FIRST_DIR, 8'hFF);
    apb(0, lsp_pkg::IDX_FIRST_LATCH, 0); chk(r, 32'h0000_00C5);
    $display("done write-back");
  endtask : t_rmw
  task automatic t_second();
    // analog pins 3,2: latch 0, ie 0, dir 0
    apb(1, lsp_pkg::IDX_SECOND_LATCH, 8'hC3);
    apb(1, lsp_pkg::IDX_SECOND_IE, 8'h33);
    apb(1, lsp_pkg::IDX_SECOND_DIR, 8'hC0);
    // no conversion runs in this bench, so port writes stay legal
    chk({s_pad.oe, s_pad.dout & 8'hC0}, 16'hC0C0);
    chk(s_dig, 8'h12);
    apb(0, lsp_pkg::IDX_SECOND_LATCH, 0); chk(r, 32'h0000_00D2);
    $display("done second port");
  endtask : t_second
  task automatic t_unmapped();
    apb(1, 12'h001, 8'hFF); chk(e, 1'b1);
    apb(0, 12'h001, 0); chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    chk(pready, 1'b1);
    $display("done unmapped");
  endtask : t_unmapped
  task automatic t_midreset();
    apb(1, lsp_pkg::IDX_SECOND_IE, 8'h00);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    apb(0, lsp_pkg::IDX_SECOND_IE, 0); chk(r, 32'h0000_00FF);
    apb(0, lsp_pkg::IDX_FIRST_SEG, 0); chk(r, 32'h0000_0000);
    chk(f_pad.oe, 8'h00);
    $display("done mid-run reset");
  endtask : t_midreset
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_first();
    t_rmw();
    t_second();
    t_unmapped();
    t_midreset();
    end_sim();
  end
endmodule : tb
`default_nettype wire
